// ---- lscc_pkg.sv ----
// Purpose: Shared constants for the light sensor command and control registers
// Assumes: One device clock; the two-wire bus pins are sampled by that clock
// Notes: Register addresses are 5-bit indices carried in the command byte
package lscc_pkg;
    // Two-wire slave address, 7 bits
    localparam logic [6:0] LSCC_SLAVE_ADDR = 7'h29;

    // Register addresses
    localparam logic [4:0] LSCC_ADDR_CTRL = 5'h00;
    localparam logic [4:0] LSCC_ADDR_CONST = 5'h13;
    localparam logic [4:0] LSCC_ADDR_DATA0_LO = 5'h14;
    localparam logic [4:0] LSCC_ADDR_DATA0_HI = 5'h15;
    localparam logic [4:0] LSCC_ADDR_DATA1_LO = 5'h16;
    localparam logic [4:0] LSCC_ADDR_DATA1_HI = 5'h17;
    localparam logic [4:0] LSCC_ADDR_TIMER_LO = 5'h18;
    localparam logic [4:0] LSCC_ADDR_TIMER_HI = 5'h19;

    // Reset values
    localparam logic [7:0] LSCC_CMD_RST = 8'h00;
    localparam logic [7:0] LSCC_CTRL_RST = 8'h00;

    // Command byte fields
    localparam int LSCC_CMD_SEL_BIT = 7;
    localparam int LSCC_CMD_TRANS_HI = 6;
    localparam int LSCC_CMD_TRANS_LO = 5;
    localparam logic [1:0] LSCC_TRANS_BYTE = 2'h0;
    localparam logic [1:0] LSCC_TRANS_WORD = 2'h1;
    localparam logic [1:0] LSCC_TRANS_BLOCK = 2'h2;
    localparam logic [1:0] LSCC_TRANS_SPECIAL = 2'h3;
    localparam logic [4:0] LSCC_SF_INT_CLEAR = 5'h01;
    localparam logic [4:0] LSCC_SF_MAN_STOP = 5'h02;
    localparam logic [4:0] LSCC_SF_MAN_START = 5'h03;

    // Control register field positions
    localparam int LSCC_CTRL_POWER_BIT = 0;
    localparam int LSCC_CTRL_ADC_EN_BIT = 1;
    localparam int LSCC_CTRL_VALID_BIT = 4;
    localparam int LSCC_CTRL_IRQ_BIT = 5;

    // Byte count reported ahead of a 32-bit block read
    localparam logic [7:0] LSCC_BLOCK_COUNT = 8'h04;
    // Integration count that selects manual mode
    localparam logic [7:0] LSCC_INTEGRATION_CYCLE_COUNT_MANUAL = 8'h00;
    localparam logic [3:0] LSCC_BITS_PER_BYTE = 4'h8;
endpackage

// ---- lscc_sync.sv ----
// Purpose: Two-flop synchroniser for a bus pin with edge detection
// Assumes: Idle level of the pin is high
// Notes: Edges are found on the second and third flops only
module lscc_sync (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Pin
    input wire logic async_i,
    // Synchronised level and edges
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= async_i;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level_o = sync;
    assign rise_o = sync & ~prev;
    assign fall_o = ~sync & prev;
endmodule

// ---- lscc_regs.sv ----
// Purpose: Two-wire slave with command decoder and control register
// Assumes: Bus pins sampled by mclk_i; register data of other blocks on same clock
// Notes: Registers other than control, constant, data and timer are reached
//        through the ext_* port; ext_rdata_i is read at the pointer, which ext_addr_o shows on writes only
//
// Operation
// - Command register selects target register and resets to zero.
// - Bits six to five choose byte, word, block or special function.
// - Outside special function, low five bits give the register address.
// - Special code 00001 clears a pending interrupt once, nothing stored.
// - In manual mode, code 00010 ends manual integration; timer becomes readable.
// - In manual mode, code 00011 begins manual integration.
// - Block transfers without count run until the master stops them.
// - SMBus block transfers carry a byte count; two-wire plain ones do not.
// - Result bytes 14h to 17h readable as one four-byte block.
// - Block read via command D3h answers with count four first.
// - Control bit five shows the interrupt output is asserted.
// - Control bit four sets when an integration cycle has finished.
// - Control bit one enables or disables both converter channels.
// - Control bit zero powers the device on or off.
// - First byte after the address with top bit one is a command; low bits stored as select.
// - Every read returns the register picked by the stored address.
// - Integration count zero selects manual integration mode.
// - Powered and outside manual mode, next integration starts without the host after results are stored.
module lscc_regs (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Converter status and data
    input wire logic [7:0] integration_cycle_count_i,
    input wire logic integ_done_i,
    input wire logic irq_event_i,
    input wire logic [15:0] ch0_data_i,
    input wire logic [15:0] ch1_data_i,
    input wire logic [15:0] manual_timer_i,
    // Control outputs
    output logic power_o,
    output logic adc_en_o,
    output logic conversion_irq_flag_o,
    output logic man_start_o,
    output logic man_stop_o,
    output logic integ_restart_o,
    // Other registers of the device
    output logic ext_wr_o,
    output logic [4:0] ext_addr_o,
    output logic [7:0] ext_wdata_o,
    input wire logic [7:0] ext_rdata_i
);
    import lscc_pkg::*;

    typedef enum logic [6:0] {
        LSCC_IDLE = 7'h01,
        LSCC_ADDR = 7'h02,
        LSCC_ADDR_ACK = 7'h04,
        LSCC_RX = 7'h08,
        LSCC_RX_ACK = 7'h10,
        LSCC_TX = 7'h20,
        LSCC_TX_ACK = 7'h40
    } lscc_state_e;

    typedef struct packed {
        lscc_state_e st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic rw;
        logic first;
        logic skip;
        logic nack;
        logic [7:0] cmd;
        logic [4:0] ptr;
        logic power;
        logic adc_en;
        logic irq;
        logic valid;
        logic sda_lvl;
        logic sda_oe;
        logic man_start;
        logic man_stop;
        logic restart;
        logic ext_wr;
        logic [4:0] ext_addr;
        logic [7:0] ext_wdata;
    } lscc_regs_s;

    lscc_regs_s s;
    lscc_regs_s next_s;
    logic scl;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic sda_rise;
    logic sda_fall;
    logic [7:0] ctrl_rd;
    logic [7:0] rdata;
    logic [1:0] trans;
    logic manual;

    lscc_sync u_scl (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .async_i(scl_i),
        .level_o(scl),
        .rise_o(scl_rise),
        .fall_o(scl_fall)
    );

    lscc_sync u_sda (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .async_i(sda_i),
        .level_o(sda),
        .rise_o(sda_rise),
        .fall_o(sda_fall)
    );

    assign trans = s.cmd[LSCC_CMD_TRANS_HI:LSCC_CMD_TRANS_LO];
    assign manual = (integration_cycle_count_i == LSCC_INTEGRATION_CYCLE_COUNT_MANUAL);

    always_comb begin
        ctrl_rd = LSCC_CTRL_RST;
        ctrl_rd[LSCC_CTRL_POWER_BIT] = s.power;
        ctrl_rd[LSCC_CTRL_ADC_EN_BIT] = s.adc_en;
        ctrl_rd[LSCC_CTRL_VALID_BIT] = s.valid;
        ctrl_rd[LSCC_CTRL_IRQ_BIT] = s.irq;
    end

    // Read data of the register under the pointer
    always_comb begin
        unique case (s.ptr)
            LSCC_ADDR_CTRL: rdata = ctrl_rd;
            LSCC_ADDR_CONST: rdata = LSCC_BLOCK_COUNT;
            LSCC_ADDR_DATA0_LO: rdata = ch0_data_i[7:0];
            LSCC_ADDR_DATA0_HI: rdata = ch0_data_i[15:8];
            LSCC_ADDR_DATA1_LO: rdata = ch1_data_i[7:0];
            LSCC_ADDR_DATA1_HI: rdata = ch1_data_i[15:8];
            LSCC_ADDR_TIMER_LO: rdata = manual_timer_i[7:0];
            LSCC_ADDR_TIMER_HI: rdata = manual_timer_i[15:8];
            default: rdata = ext_rdata_i;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.ext_wr = 1'b0;
        next_s.man_start = 1'b0;
        next_s.man_stop = 1'b0;
        next_s.restart = 1'b0;
        next_s.sda_lvl = 1'b0;
        if (scl && sda_fall) begin
            // Start or repeated start
            next_s.st = LSCC_ADDR;
            next_s.cnt = 4'h0;
            next_s.first = 1'b1;
            next_s.skip = 1'b0;
            next_s.ptr = s.cmd[4:0];
            next_s.sda_oe = 1'b0;
        end else if (scl && sda_rise) begin
            // Stop ends any transfer, block ones included
            next_s.st = LSCC_IDLE;
            next_s.sda_oe = 1'b0;
        end else begin
            unique case (s.st)
                LSCC_IDLE: begin
                    next_s.sda_oe = 1'b0;
                end
                LSCC_ADDR: begin
                    if (scl_rise) begin
                        next_s.shreg = {s.shreg[6:0], sda};
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (scl_fall && s.cnt == LSCC_BITS_PER_BYTE) begin
                        if (s.shreg[7:1] == LSCC_SLAVE_ADDR) begin
                            next_s.rw = s.shreg[0];
                            next_s.st = LSCC_ADDR_ACK;
                            next_s.sda_oe = 1'b1;
                        end else begin
                            next_s.st = LSCC_IDLE;
                        end
                    end
                end
                LSCC_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_s.cnt = 4'h0;
                        if (s.rw) begin
                            next_s.st = LSCC_TX;
                            next_s.shreg = rdata;
                            next_s.sda_oe = ~rdata[7];
                        end else begin
                            next_s.st = LSCC_RX;
                            next_s.sda_oe = 1'b0;
                        end
                    end
                end
                LSCC_RX: begin
                    if (scl_rise) begin
                        next_s.shreg = {s.shreg[6:0], sda};
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (scl_fall && s.cnt == LSCC_BITS_PER_BYTE) begin
                        next_s.st = LSCC_RX_ACK;
                        next_s.sda_oe = 1'b1;
                        next_s.first = 1'b0;
                        if (s.first && s.shreg[LSCC_CMD_SEL_BIT]) begin
                            next_s.cmd = s.shreg;
                            next_s.ptr = s.shreg[4:0];
                            // Byte count after a block command is ignored
                            next_s.skip = (s.shreg[6:5] == LSCC_TRANS_BLOCK);
                            if (s.shreg[6:5] == LSCC_TRANS_SPECIAL) begin
                                if (s.shreg[4:0] == LSCC_SF_INT_CLEAR) begin
                                    next_s.irq = 1'b0;
                                end
                                if (s.shreg[4:0] == LSCC_SF_MAN_STOP && manual) begin
                                    next_s.man_stop = 1'b1;
                                end
                                if (s.shreg[4:0] == LSCC_SF_MAN_START && manual) begin
                                    next_s.man_start = 1'b1;
                                end
                            end
                        end else if (s.skip) begin
                            next_s.skip = 1'b0;
                        end else begin
                            if (s.ptr == LSCC_ADDR_CTRL) begin
                                next_s.power = s.shreg[LSCC_CTRL_POWER_BIT];
                                next_s.adc_en = s.shreg[LSCC_CTRL_ADC_EN_BIT];
                            end else begin
                                next_s.ext_wr = 1'b1;
                                next_s.ext_addr = s.ptr;
                                next_s.ext_wdata = s.shreg;
                            end
                            if (trans == LSCC_TRANS_WORD || trans == LSCC_TRANS_BLOCK) begin
                                next_s.ptr = s.ptr + 5'h01;
                            end
                        end
                    end
                end
                LSCC_RX_ACK: begin
                    if (scl_fall) begin
                        next_s.st = LSCC_RX;
                        next_s.cnt = 4'h0;
                        next_s.sda_oe = 1'b0;
                    end
                end
                LSCC_TX: begin
                    if (scl_rise) begin
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s.cnt == LSCC_BITS_PER_BYTE) begin
                            next_s.st = LSCC_TX_ACK;
                            next_s.sda_oe = 1'b0;
                        end else begin
                            next_s.shreg = {s.shreg[6:0], 1'b0};
                            next_s.sda_oe = ~s.shreg[6];
                        end
                    end
                end
                LSCC_TX_ACK: begin
                    if (scl_rise) begin
                        next_s.nack = sda;
                        if (trans == LSCC_TRANS_WORD || trans == LSCC_TRANS_BLOCK) begin
                            next_s.ptr = s.ptr + 5'h01;
                        end
                    end else if (scl_fall) begin
                        if (s.nack) begin
                            next_s.st = LSCC_IDLE;
                        end else begin
                            next_s.st = LSCC_TX;
                            next_s.cnt = 4'h0;
                            next_s.shreg = rdata;
                            next_s.sda_oe = ~rdata[7];
                        end
                    end
                end
                default: begin
                    next_s.st = LSCC_IDLE;
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end
        // Hardware events win over a clear in the same cycle
        if (irq_event_i) begin
            next_s.irq = 1'b1;
        end
        if (!next_s.adc_en) begin
            next_s.valid = 1'b0;
        end
        if (integ_done_i && s.adc_en) begin
            next_s.valid = 1'b1;
            next_s.restart = s.power && !manual;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s <= '0;
            s.st <= LSCC_IDLE;
            s.cmd <= LSCC_CMD_RST;
        end else begin
            s <= next_s;
        end
    end

    assign sda_o = s.sda_lvl;
    assign sda_oe_o = s.sda_oe;
    assign power_o = s.power;
    assign adc_en_o = s.adc_en;
    assign conversion_irq_flag_o = s.irq;
    assign man_start_o = s.man_start;
    assign man_stop_o = s.man_stop;
    assign integ_restart_o = s.restart;
    assign ext_wr_o = s.ext_wr;
    assign ext_addr_o = s.ext_addr;
    assign ext_wdata_o = s.ext_wdata;
endmodule

// ---- lscc_regs_sva.sv ----
// Purpose: Port checks for the command and control register block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every instance of lscc_regs
module lscc_regs_sva
    import lscc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Watched ports
    input wire logic sda_oe_o,
    input wire logic [7:0] integration_cycle_count_i,
    input wire logic integ_done_i,
    input wire logic irq_event_i,
    input wire logic power_o,
    input wire logic adc_en_o,
    input wire logic conversion_irq_flag_o,
    input wire logic man_start_o,
    input wire logic man_stop_o,
    input wire logic integ_restart_o,
    input wire logic ext_wr_o,
    input wire logic [4:0] ext_addr_o
);
    default clocking dc @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    chk_restart_auto: assert property (
        integ_done_i && power_o && adc_en_o
        && integration_cycle_count_i != LSCC_INTEGRATION_CYCLE_COUNT_MANUAL |=> integ_restart_o)
        else $error("restart pulse missing");
    chk_restart_cause: assert property (integ_restart_o |-> $past(integ_done_i))
        else $error("restart without a finished integration");
    chk_irq_set: assert property (irq_event_i |=> conversion_irq_flag_o)
        else $error("interrupt flag not set");
    chk_irq_cause: assert property ($rose(conversion_irq_flag_o) |-> $past(irq_event_i))
        else $error("interrupt flag rose without an event");
    chk_irq_clear: assert property ($fell(conversion_irq_flag_o) |-> ##[0:3] sda_oe_o)
        else $error("interrupt flag fell outside a bus byte");
    chk_man_start: assert property (
        man_start_o |-> $past(integration_cycle_count_i) == LSCC_INTEGRATION_CYCLE_COUNT_MANUAL)
        else $error("manual start outside manual mode");
    chk_man_stop: assert property (
        man_stop_o |-> $past(integration_cycle_count_i) == LSCC_INTEGRATION_CYCLE_COUNT_MANUAL)
        else $error("manual stop outside manual mode");
    chk_ctrl_write: assert property ($changed({power_o, adc_en_o}) |-> ##[0:3] sda_oe_o)
        else $error("control bits moved outside a write");
    chk_ext_addr: assert property (ext_wr_o |-> ext_addr_o != LSCC_ADDR_CTRL)
        else $error("control write passed to other registers");
    chk_ack_stand: assert property ($rose(sda_oe_o) |-> sda_oe_o[*4])
        else $error("data line drive too short");
endmodule

bind lscc_regs lscc_regs_sva lscc_regs_sva_inst (
    .mclk_i, .resetn_i, .sda_oe_o, .integration_cycle_count_i, .integ_done_i,
    .irq_event_i, .power_o, .adc_en_o, .conversion_irq_flag_o, .man_start_o,
    .man_stop_o, .integ_restart_o, .ext_wr_o, .ext_addr_o
);

// ---- lscc_host.sv ----
// Purpose: Two-wire bus master model for the register block
// Assumes: Open-drain data line with pull-up; 160 ns bits, 5 mclk low, 3 high
// Notes: Clock line stands high between frames
module lscc_host (
    // Clock and resolved data line
    input wire logic mclk_i,
    input wire logic sda_i,
    // Bus drive
    output logic scl_o,
    output logic sda_pull_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // Data is set late in the low phase so a slave acknowledge has ended
    task automatic bitx(input logic b, output logic r);
        w(3);
        sda_pull_o = ~b;
        w(2);
        scl_o = 1'b1;
        w(2);
        r = sda_i;
        w(1);
        scl_o = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                        output logic sack);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(~mack, a);
        sack = ~a;
    endtask

    task automatic start();
        w(4);
        sda_pull_o = 1'b0;
        w(2);
        scl_o = 1'b1;
        w(2);
        sda_pull_o = 1'b1;
        w(2);
        scl_o = 1'b0;
    endtask

    // Ends every transfer, block ones included
    task automatic stop();
        w(3);
        sda_pull_o = 1'b1;
        w(2);
        scl_o = 1'b1;
        w(2);
        sda_pull_o = 1'b0;
        w(2);
    endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the command and control register block
// Assumes: Bus master model at 160 ns per bit, mclk at 20 ns
// Notes: Plain reads run from a table; events and specials follow
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import lscc_pkg::*;

    typedef struct packed { logic [7:0] cmd; logic [7:0] exp; } lscc_row_s;
    localparam lscc_row_s ROWS [8] = '{'{8'h94, 8'h34}, '{8'h95, 8'h12}, '{8'h96, 8'h78},
        '{8'h97, 8'h56}, '{8'h98, 8'hBC}, '{8'h99, 8'h9A}, '{8'h93, 8'h04}, '{8'h81, 8'h5A}};

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] cnt = 8'hFF;
    logic done = 1'b0;
    logic irq = 1'b0;
    logic scl, pull, sda_oe, sda_o, pwr, aen, iflag, mst, msp, rst, xwr, ack;
    logic [4:0] xaddr;
    logic [7:0] xwd;
    logic [12:0] xcap = 13'h0000;
    logic [3:0] seen = 4'h0;
    logic [7:0] got[$];
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    // Open-drain line with pull-up: the device pulls low only when enabled and driving zero
    wire sda = ~(pull | (sda_oe & ~sda_o));

    always #10 mclk = ~mclk;

    lscc_host host (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));

    lscc_regs lscc_regs_inst (
        .mclk_i(mclk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .integration_cycle_count_i(cnt), .integ_done_i(done),
        .irq_event_i(irq), .ch0_data_i(16'h1234), .ch1_data_i(16'h5678),
        .manual_timer_i(16'h9ABC), .power_o(pwr), .adc_en_o(aen),
        .conversion_irq_flag_o(iflag), .man_start_o(mst), .man_stop_o(msp),
        .integ_restart_o(rst), .ext_wr_o(xwr), .ext_addr_o(xaddr), .ext_wdata_o(xwd),
        .ext_rdata_i(8'h5A)
    );

    // Pulses are caught here so the main thread can look at them later
    always @(posedge mclk) begin
        seen <= seen | {xwr, rst, msp, mst};
        if (xwr) xcap <= {xaddr, xwd};
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chkq(input logic [39:0] e);
        foreach (got[i]) chk(got[i], e[8 * (got.size() - 1 - i) +: 8]);
    endtask

    task automatic send(input logic [7:0] b);
        logic [7:0] r;
        host.xfer(b, 1'b0, r, ack);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input bit nd);
        host.start();
        send({LSCC_SLAVE_ADDR, 1'b0});
        send(cmd);
        chk({7'h00, ack}, 8'h01);
        if (nd) send(d);
        host.stop();
    endtask

    task automatic rd(input logic [7:0] cmd, input bit wc, input int n);
        logic [7:0] r;
        logic a;
        got.delete();
        host.start();
        if (wc) begin
            send({LSCC_SLAVE_ADDR, 1'b0});
            send(cmd);
            host.start();
        end
        send({LSCC_SLAVE_ADDR, 1'b1});
        for (int i = 0; i < n; i++) begin
            host.xfer(8'hFF, i < n - 1, r, a);
            got.push_back(r);
        end
        host.stop();
    endtask

    // Reset, then a receive byte with no command must return the control register
    task automatic do_reset();
        @(posedge mclk);
        #1 resetn = 1'b0;
        repeat (4) @(posedge mclk);
        #1 chk({5'h00, pwr, aen, iflag}, 8'h00);
        resetn = 1'b1;
        repeat (4) @(posedge mclk);
        #1 rd(8'h00, 1'b0, 1);
        chk(got[0], LSCC_CTRL_RST);
        $display("test reset done");
    endtask

    task automatic pulse_events();
        done = 1'b1;
        irq = 1'b1;
        @(posedge mclk);
        #1 done = 1'b0;
        irq = 1'b0;
    endtask

    initial begin
        do_reset();
        foreach (ROWS[i]) begin
            rd(ROWS[i].cmd, 1'b1, 1);
            chk(got[0], ROWS[i].exp);
        end
        $display("test table done");
        wr(8'h80, 8'h03, 1'b1);
        chk({6'h00, pwr, aen}, 8'h03);
        pulse_events();
        rd(8'h80, 1'b1, 1);
        chk(got[0], 8'h33);
        chk({7'h00, seen[2]}, 8'h01);
        wr(8'hE1, 8'h00, 1'b0);
        chk({7'h00, iflag}, 8'h00);
        rd(8'h80, 1'b1, 1);
        chk(got[0], 8'h13);
        $display("test control done");
        rd(8'hD3, 1'b1, 5);
        chkq(40'h0434127856);
        rd(8'hD4, 1'b1, 4);
        chkq(40'h0034127856);
        rd(8'hB4, 1'b1, 2);
        chkq(40'h0000003412);
        rd(8'h94, 1'b1, 2);
        chkq(40'h0000003434);
        $display("test block done");
        cnt = LSCC_INTEGRATION_CYCLE_COUNT_MANUAL;
        seen = 4'h0;
        wr(8'hE3, 8'h00, 1'b0);
        wr(8'hE2, 8'h00, 1'b0);
        chk({6'h00, seen[1:0]}, 8'h03);
        cnt = 8'hFF;
        seen = 4'h0;
        wr(8'hE3, 8'h00, 1'b0);
        wr(8'hE2, 8'h00, 1'b0);
        chk({6'h00, seen[1:0]}, 8'h00);
        $display("test manual done");
        wr(8'h81, 8'hA5, 1'b1);
        chk({7'h00, seen[3]}, 8'h01);
        chk({3'h0, xcap[12:8]}, 8'h01);
        chk(xcap[7:0], 8'hA5);
        // Block write to 01h: the count byte must be dropped, data then steps the address
        host.start();
        send({LSCC_SLAVE_ADDR, 1'b0});
        send(8'hC1);
        send(8'h04);
        send(8'h11);
        send(8'h22);
        host.stop();
        chk({3'h0, xcap[12:8]}, 8'h02);
        chk(xcap[7:0], 8'h22);
        $display("test other write done");
        do_reset();
        final_report();
    end
endmodule
